// File: hdl/smbsp_top.sv
// Contract
// [R1] answer only address 0x2e plus direction bit
// [R2] nine clocks per byte, ack ninth
// [R3] data changes only while clock low
// [R4] master ends write with stop
// [R5] master ends read with nack, stop
// [R6] direction fixed by address byte
// [R7] writes one or two bytes, reads one
// [R8] first byte to pointer, second stored
// [R9] plain read returns pointed register
// [R10] send byte sets pointer for read
// [R11] write byte updates addressed register
// [R12] receive byte returns one byte, nack
// [R13] repeated start accepted as new transfer
// [R14] alerting: answer alert address with own address
// [R15] arbitrate while sending alert reply
// [R16] alert released only once cause ceased
// [R17] bus idle timeout abandons transfer
// [R18] config bit 6 disables the timeout
// [R19] lock bit blocks critical writes until reset
// [R20] open-drain active-low alert output
// [R21] other addresses left unanswered
`timescale 1ns/100ps
module smbsp_top
	import smbsp_pkg::*;
#(
	parameter int         TIMEOUT_CYC = smbsp_pkg::TIMEOUT_CYC,
	parameter logic [7:0] LOCK_LO     = smbsp_pkg::LOCK_FIRST,
	parameter logic [7:0] LOCK_HI     = smbsp_pkg::LOCK_LAST
) (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       link_clk_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic       alert_cond_i,
	output logic            alert_o,
	output logic            alert_oe_o,
	input  wire logic [7:0] reg_rdata_i,
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_wr_o,
	output logic      [7:0] cfg1_o,
	output logic            lock_o
);
	import smbsp_pkg::*;

	generate
		if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (1 << TO_W)) begin : g_bad_timeout
			$error("timeout count out of range");
		end
		if (LOCK_LO > LOCK_HI) begin : g_bad_lock
			$error("lock range reversed");
		end
	endgenerate

	function automatic logic addr_hit(input logic [7:0] a, input logic [6:0] want);
		addr_hit = (a[7:1] == want);
	endfunction

	// link domain state
	typedef struct packed {
		smbsp_state_t     st;
		logic [3:0]       bits;
		logic [7:0]       shreg;
		logic [7:0]       ptr;
		logic [7:0]       rd_byte;
		logic [1:0]       nbyte;
		logic             rw;
		logic             ara;
		logic             lost;
		logic             sda_oe;
		logic             sda_out;
		logic             scl_q;
		logic             sda_q;
		logic             abort_q;
		logic             send;
		logic [XW-1:0]    xdata;
		logic             busy;
	} smbsp_link_t;

	// core domain state
	typedef struct packed {
		logic [7:0]       cfg;
		logic [7:0]       ptr;
		logic [7:0]       addr;
		logic [7:0]       wdata;
		logic             wr;
		logic             alert;
		logic             alert_out;
		logic [TO_W-1:0]  cnt;
		logic             abort_t;
		logic             scl_q;
		logic             send;
		logic [7:0]       rdata;
	} smbsp_core_t;

	smbsp_link_t   l;
	smbsp_link_t   next_l;
	smbsp_core_t   c;
	smbsp_core_t   next_c;

	logic [1:0]    pins_l;
	logic [1:0]    ctl_l;
	logic [1:0]    mon_c;
	logic          scl_l;
	logic          sda_l;
	logic          abort_l;
	logic          alert_l;
	logic          scl_c;
	logic          busy_c;
	logic          cmd_v;
	logic [XW-1:0] cmd_d;
	logic          rd_busy;
	logic          rd_v;
	logic [7:0]    rd_d;
	logic          scl_rise;
	logic          scl_fall;
	logic          start_c;
	logic          stop_c;
	logic [7:0]    tx_first;

	// pin and control crossings, pins inverted so reset reads an idle high bus
	smbsp_sync #(.W(2)) u_pin_sync (
		.clk_i   (link_clk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({~scl_i, ~sda_i}),
		.q_o     (pins_l)
	);

	smbsp_sync #(.W(2)) u_ctl_sync (
		.clk_i   (link_clk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({c.abort_t, c.alert}),
		.q_o     (ctl_l)
	);

	smbsp_sync #(.W(2)) u_mon_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({~scl_i, l.busy}),
		.q_o     (mon_c)
	);

	assign scl_l   = ~pins_l[1];
	assign sda_l   = ~pins_l[0];
	assign abort_l = ctl_l[1];
	assign alert_l = ctl_l[0];
	assign scl_c   = ~mon_c[1];
	assign busy_c  = mon_c[0];

	// pointer, writes and alert replies to the core
	smbsp_xfer #(.W(XW)) u_cmd_xfer (
		.src_clk_i   (link_clk_i),
		.src_rst_n_i (rst_n_i),
		.send_i      (l.send),
		.data_i      (l.xdata),
		.busy_o      (),
		.dst_clk_i   (clk_i),
		.dst_rst_n_i (rst_n_i),
		.valid_o     (cmd_v),
		.data_o      (cmd_d)
	);

	// pointed register byte refreshed to the link
	smbsp_xfer #(.W(8)) u_rd_xfer (
		.src_clk_i   (clk_i),
		.src_rst_n_i (rst_n_i),
		.send_i      (c.send),
		.data_i      (c.rdata),
		.busy_o      (rd_busy),
		.dst_clk_i   (link_clk_i),
		.dst_rst_n_i (rst_n_i),
		.valid_o     (rd_v),
		.data_o      (rd_d)
	);

	// bus conditions
	assign scl_rise = scl_l & ~l.scl_q;
	assign scl_fall = ~scl_l & l.scl_q;
	assign start_c  = scl_l & l.scl_q & l.sda_q & ~sda_l;
	assign stop_c   = scl_l & l.scl_q & ~l.sda_q & sda_l;
	assign tx_first = l.ara ? {DEV_ADDR, 1'b0} : l.rd_byte;

	always_comb begin
		next_l         = l;
		next_l.scl_q   = scl_l;
		next_l.sda_q   = sda_l;
		next_l.abort_q = abort_l;
		next_l.send    = 1'b0;
		next_l.sda_out = 1'b0;
		if (rd_v) begin
			next_l.rd_byte = rd_d;
		end
		if (abort_l != l.abort_q) begin
			next_l.st     = ST_IDLE; // [R17]
			next_l.sda_oe = 1'b0; // [R17]
		end else if (start_c) begin
			next_l.st     = ST_ADDR; // [R6] [R13]
			next_l.bits   = 4'h0;
			next_l.sda_oe = 1'b0;
			next_l.lost   = 1'b0;
		end else if (stop_c) begin
			next_l.st     = ST_IDLE; // [R3] [R4] [R5]
			next_l.sda_oe = 1'b0;
		end else if (scl_rise) begin
			case (l.st)
				ST_ADDR, ST_RX: begin
					next_l.shreg = {l.shreg[6:0], sda_l}; // [R2]
					next_l.bits  = l.bits + 4'h1;
				end
				ST_TX: begin
					next_l.bits = l.bits + 4'h1;
					if (!l.sda_oe && !sda_l) begin
						next_l.lost = 1'b1; // [R15]
					end
				end
				ST_TX_ACK: begin
					next_l.st = ST_WAIT; // [R7] [R12]
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (l.st)
				ST_ADDR: begin
					if (l.bits == BITS_PER_BYTE) begin
						if (addr_hit(l.shreg, DEV_ADDR)) begin
							next_l.st     = ST_ADDR_ACK; // [R1]
							next_l.sda_oe = 1'b1;
							next_l.rw     = l.shreg[0]; // [R6]
							next_l.ara    = 1'b0;
						end else if (addr_hit(l.shreg, ARA_ADDR) && l.shreg[0] && alert_l) begin
							next_l.st     = ST_ADDR_ACK; // [R14]
							next_l.sda_oe = 1'b1;
							next_l.rw     = 1'b1;
							next_l.ara    = 1'b1;
						end else begin
							next_l.st = ST_WAIT; // [R21]
						end
					end
				end
				ST_ADDR_ACK: begin
					next_l.bits = 4'h0;
					if (l.rw) begin
						next_l.st     = ST_TX; // [R9] [R12]
						next_l.shreg  = tx_first;
						next_l.sda_oe = ~tx_first[7]; // [R3]
						next_l.lost   = 1'b0;
					end else begin
						next_l.st     = ST_RX;
						next_l.sda_oe = 1'b0;
						next_l.nbyte  = 2'h0;
					end
				end
				ST_RX: begin
					if (l.bits == BITS_PER_BYTE) begin
						if (l.nbyte < MAX_WR_BYTES) begin
							next_l.st     = ST_RX_ACK; // [R10] [R11]
							next_l.sda_oe = 1'b1;
							next_l.send   = 1'b1;
							if (l.nbyte == 2'h0) begin
								next_l.ptr   = l.shreg; // [R8] [R10]
								next_l.xdata = {1'b0, 1'b0, l.shreg, l.shreg};
							end else begin
								next_l.xdata = {1'b0, 1'b1, l.ptr, l.shreg}; // [R8] [R11]
							end
						end else begin
							next_l.st = ST_WAIT; // [R7]
						end
					end
				end
				ST_RX_ACK: begin
					next_l.st     = ST_RX;
					next_l.sda_oe = 1'b0;
					next_l.bits   = 4'h0;
					next_l.nbyte  = l.nbyte + 2'h1;
				end
				ST_TX: begin
					if (l.bits == BITS_PER_BYTE) begin
						next_l.st     = ST_TX_ACK; // [R2]
						next_l.sda_oe = 1'b0;
						if (l.ara && !l.lost) begin
							next_l.send  = 1'b1; // [R16]
							next_l.xdata = {1'b1, 1'b0, l.ptr, 8'h00};
						end
					end else begin
						next_l.shreg  = {l.shreg[6:0], 1'b0};
						next_l.sda_oe = ~l.shreg[6] & ~l.lost; // [R15]
					end
				end
				default: begin
				end
			endcase
		end
		next_l.busy = (next_l.st != ST_IDLE);
	end

	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			l         <= '0;
			l.st      <= ST_IDLE;
			l.ptr     <= PTR_RESET;
			l.scl_q   <= 1'b1;
			l.sda_q   <= 1'b1;
		end else begin
			l <= next_l;
		end
	end

	// core domain: config, lock, register port, alert, timeout
	always_comb begin
		next_c       = c;
		next_c.wr    = 1'b0;
		next_c.scl_q = scl_c;
		next_c.send  = ~rd_busy & ~c.send;
		next_c.rdata = (c.ptr == CFG1_OFFSET) ? c.cfg : reg_rdata_i; // [R9]
		next_c.alert = alert_cond_i | (c.alert & ~(cmd_v & cmd_d[XF_ARA])); // [R16]
		next_c.alert_out = 1'b0;
		if (cmd_v && !cmd_d[XF_ARA]) begin
			next_c.ptr  = cmd_d[XF_PTR +: 8];
			next_c.addr = cmd_d[XF_PTR +: 8];
			if (cmd_d[XF_WR]) begin
				if (cmd_d[XF_PTR +: 8] == CFG1_OFFSET) begin
					if (!c.cfg[CFG1_LOCK_BIT]) begin
						next_c.cfg = cmd_d[XF_DATA +: 8]; // [R11] [R18]
					end
				end else if (!(c.cfg[CFG1_LOCK_BIT] && cmd_d[XF_PTR +: 8] >= LOCK_LO
					&& cmd_d[XF_PTR +: 8] <= LOCK_HI)) begin
					next_c.wr    = 1'b1; // [R19]
					next_c.wdata = cmd_d[XF_DATA +: 8];
				end
			end
		end
		if (!busy_c || (scl_c != c.scl_q) || c.cfg[CFG1_BUS_TIMEOUT_DISABLE_BIT]) begin
			next_c.cnt = '0; // [R18]
		end else if (c.cnt == TO_W'(TIMEOUT_CYC - 1)) begin
			next_c.cnt     = '0;
			next_c.abort_t = ~c.abort_t; // [R17]
		end else begin
			next_c.cnt = c.cnt + TO_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			c       <= '0;
			c.cfg   <= CFG1_RESET;
			c.ptr   <= PTR_RESET;
			c.addr  <= PTR_RESET;
			c.scl_q <= 1'b1;
		end else begin
			c <= next_c;
		end
	end

	assign sda_o       = l.sda_out;
	assign sda_oe_o    = l.sda_oe;
	assign alert_o     = c.alert_out;
	assign alert_oe_o  = c.alert; // [R20]
	assign reg_addr_o  = c.addr;
	assign reg_wdata_o = c.wdata;
	assign reg_wr_o    = c.wr;
	assign cfg1_o      = c.cfg;
	assign lock_o      = c.cfg[CFG1_LOCK_BIT]; // [R19]
endmodule

// File: hdl/smbsp_pkg.sv
package smbsp_pkg;
	// bus addresses, 7-bit form
	localparam logic [6:0] DEV_ADDR       = 7'h2e;
	localparam logic [6:0] ARA_ADDR       = 7'h0c;
	// register map
	localparam logic [7:0] CFG1_OFFSET    = 8'h40;
	localparam logic [7:0] CFG1_RESET     = 8'h00;
	localparam int         CFG1_BUS_TIMEOUT_DISABLE_BIT = 6;
	localparam int         CFG1_LOCK_BIT  = 1;
	localparam logic [7:0] PTR_RESET      = 8'h00;
	localparam logic [7:0] LOCK_FIRST     = 8'h40;
	localparam logic [7:0] LOCK_LAST      = 8'h7f;
	// framing
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	localparam logic [1:0] MAX_WR_BYTES   = 2'h2;
	// timing
	localparam int         CLK_HZ         = 10_000_000;
	localparam int         TIMEOUT_MS     = 35;
	localparam int         TIMEOUT_CYC    = TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int         TO_W           = 20;
	// crossing payload: {ara, write, pointer, data}
	localparam int         XW             = 18;
	localparam int         XF_ARA         = 17;
	localparam int         XF_WR          = 16;
	localparam int         XF_PTR         = 8;
	localparam int         XF_DATA        = 0;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ADDR_ACK = 3'b011,
		ST_RX       = 3'b010,
		ST_RX_ACK   = 3'b110,
		ST_TX       = 3'b111,
		ST_TX_ACK   = 3'b101,
		ST_WAIT     = 3'b100
	} smbsp_state_t;
endpackage

// File: hdl/smbsp_sync.sv
`timescale 1ns/100ps
module smbsp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} smbsp_sync_t;

	smbsp_sync_t r;
	smbsp_sync_t next_r;

	always_comb begin
		next_r    = r;
		next_r.s1 = d_i;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q_o = r.s2;
endmodule

// File: hdl/smbsp_xfer.sv
`timescale 1ns/100ps
module smbsp_xfer #(
	parameter int W = 8
) (
	input  wire logic         src_clk_i,
	input  wire logic         src_rst_n_i,
	input  wire logic         send_i,
	input  wire logic [W-1:0] data_i,
	output logic              busy_o,
	input  wire logic         dst_clk_i,
	input  wire logic         dst_rst_n_i,
	output logic              valid_o,
	output logic      [W-1:0] data_o
);
	typedef struct packed {
		logic         req;
		logic [W-1:0] data;
	} smbsp_xsrc_t;

	typedef struct packed {
		logic         ack;
		logic         valid;
		logic [W-1:0] data;
	} smbsp_xdst_t;

	smbsp_xsrc_t s;
	smbsp_xsrc_t next_s;
	smbsp_xdst_t d;
	smbsp_xdst_t next_d;
	logic        ack_s;
	logic        req_s;

	smbsp_sync #(.W(1)) u_ack_sync (
		.clk_i   (src_clk_i),
		.rst_n_i (src_rst_n_i),
		.d_i     (d.ack),
		.q_o     (ack_s)
	);

	smbsp_sync #(.W(1)) u_req_sync (
		.clk_i   (dst_clk_i),
		.rst_n_i (dst_rst_n_i),
		.d_i     (s.req),
		.q_o     (req_s)
	);

	// source holds data stable until the ack returns
	always_comb begin
		next_s = s;
		if (send_i && (s.req == ack_s)) begin
			next_s.req  = ~s.req;
			next_s.data = data_i;
		end
	end

	always_ff @(posedge src_clk_i or negedge src_rst_n_i) begin
		if (!src_rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign busy_o = s.req ^ ack_s;

	always_comb begin
		next_d       = d;
		next_d.valid = 1'b0;
		if (req_s != d.ack) begin
			next_d.ack   = req_s;
			next_d.valid = 1'b1;
			next_d.data  = s.data;
		end
	end

	always_ff @(posedge dst_clk_i or negedge dst_rst_n_i) begin
		if (!dst_rst_n_i) begin
			d <= '0;
		end else begin
			d <= next_d;
		end
	end

	assign valid_o = d.valid;
	assign data_o  = d.data;
endmodule

// File: tb/smbsp_properties.sv
`timescale 1ns/100ps
module smbsp_properties
	import smbsp_pkg::*;
#(
	parameter int         TIMEOUT_CYC = smbsp_pkg::TIMEOUT_CYC,
	parameter logic [7:0] LOCK_LO     = smbsp_pkg::LOCK_FIRST,
	parameter logic [7:0] LOCK_HI     = smbsp_pkg::LOCK_LAST
) (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       link_clk_i,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_o,
	input wire logic       alert_cond_i,
	input wire logic       alert_o,
	input wire logic       alert_oe_o,
	input wire logic [7:0] reg_rdata_i,
	input wire logic [7:0] reg_addr_o,
	input wire logic [7:0] reg_wdata_o,
	input wire logic       reg_wr_o,
	input wire logic [7:0] cfg1_o,
	input wire logic       lock_o
);
	int   idle_cnt;
	logic scl_q;
	// cycles since the bus clock last moved
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idle_cnt <= 0;
			scl_q    <= 1'b1;
		end else begin
			scl_q    <= scl_i;
			idle_cnt <= (scl_q != scl_i) ? 0 : idle_cnt + 1;
		end
	end
	sequence s_start;
		scl_i && $fell(sda_i);
	endsequence
	a_oe_clock_low: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		$changed(sda_oe_o) |-> !scl_i || idle_cnt >= TIMEOUT_CYC) else $error("sda moved while clock high");
	a_start_released: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
		s_start |-> !sda_oe_o) else $error("sda held at start");
	a_timeout_release: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		idle_cnt > TIMEOUT_CYC + 30 && !cfg1_o[CFG1_BUS_TIMEOUT_DISABLE_BIT] |-> !sda_oe_o) else $error("sda held past timeout");
	a_wr_single: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reg_wr_o |=> !reg_wr_o) else $error("write strobe too long");
	a_lock_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reg_wr_o && lock_o |-> reg_addr_o < LOCK_LO || reg_addr_o > LOCK_HI) else $error("locked write");
	a_lock_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		lock_o |=> lock_o && $stable(cfg1_o)) else $error("lock or config changed");
	a_cfg_internal: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		reg_wr_o |-> reg_addr_o != CFG1_OFFSET) else $error("config sent outside");
	a_alert_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		alert_cond_i |=> alert_oe_o) else $error("alert not raised");
endmodule
bind smbsp_top smbsp_properties #(.TIMEOUT_CYC(TIMEOUT_CYC), .LOCK_LO(LOCK_LO), .LOCK_HI(LOCK_HI)) chk (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_o(sda_oe_o), .alert_cond_i(alert_cond_i), .alert_o(alert_o), .alert_oe_o(alert_oe_o),
	.reg_rdata_i(reg_rdata_i), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o), .reg_wr_o(reg_wr_o),
	.cfg1_o(cfg1_o), .lock_o(lock_o));

// File: tb/smbsp_master.sv
`timescale 1ns/100ps
module smbsp_master (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	initial begin
		scl_o     = 1'b1;
		sda_low_o = 1'b0;
	end
	task automatic quarter;
		repeat (3) @(negedge clk_i);
	endtask
	// data set while clock low, sampled while high
	task automatic bit_io(input logic b, output logic r);
		sda_low_o = ~b;
		quarter();
		scl_o = 1'b1;
		quarter();
		r = sda_i;
		quarter();
		scl_o = 1'b0;
		quarter();
	endtask
	task automatic start;
		sda_low_o = 1'b0;
		quarter();
		scl_o = 1'b1;
		quarter();
		sda_low_o = 1'b1;
		quarter();
		scl_o = 1'b0;
		quarter();
	endtask
	task automatic stop;
		sda_low_o = 1'b1;
		quarter();
		scl_o = 1'b1;
		quarter();
		sda_low_o = 1'b0;
		quarter();
	endtask
	// eight bits msb first, then ack slot
	task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] r, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(~mack, a);
		ack = ~a;
	endtask
endmodule

// File: tb/smbus_slave_register_port_test.sv
`timescale 1ns/100ps
module smbus_slave_register_port_test;
	import smbsp_pkg::*;
	logic       clk_i, link_clk_i, rst_n_i, alert_cond_i, scl, sda_low, sda, sda_oe, alert_oe, reg_wr, lock, a;
	logic       sda_d, alert_d, alert_n;
	logic [7:0] rdata, reg_addr, reg_wdata, cfg1, r;
	logic [7:0] regs [256];
	int         bad_count, check_count, wr_count, cyc;
	assign sda     = ~((sda_oe & ~sda_d) | sda_low);
	assign alert_n = ~(alert_oe & ~alert_d);
	assign rdata = regs[reg_addr];
	smbsp_top #(.TIMEOUT_CYC(200)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe), .alert_cond_i(alert_cond_i), .alert_o(alert_d),
		.alert_oe_o(alert_oe), .reg_rdata_i(rdata), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
		.reg_wr_o(reg_wr), .cfg1_o(cfg1), .lock_o(lock));
	smbsp_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#3.3;
		forever #7.5 link_clk_i = ~link_clk_i;
	end
	always @(posedge clk_i) begin
		if (reg_wr) begin
			regs[reg_addr] <= reg_wdata;
			wr_count++;
		end
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			bad_count++;
		end
	endtask
	task automatic put(input logic [7:0] b, input logic ack_exp);
		m.byte_io(b, 1'b0, r, a);
		chk("ack", {7'h0, ack_exp}, {7'h0, a});
	endtask
	task automatic get(input logic [7:0] exp);
		m.byte_io(8'hff, 1'b0, r, a);
		chk("rdata", exp, r);
	endtask
	task automatic wreg(input logic [7:0] p, input logic [7:0] d);
		m.start();
		put(8'h5c, 1'b1);
		put(p, 1'b1);
		put(d, 1'b1);
		m.stop();
		repeat (20) @(negedge clk_i);
	endtask
	initial begin
		rst_n_i      = 1'b0;
		alert_cond_i = 1'b0;
		for (int i = 0; i < 256; i++) regs[i] = 8'(i);
		repeat (10) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (5) @(negedge clk_i);
		chk("cfg1", 8'h00, cfg1);
		chk("lock", 8'h00, {7'h0, lock});
		wreg(8'h10, 8'ha5);
		m.start();
		put(8'h5c, 1'b1);
		put(8'h10, 1'b1);
		m.start();
		put(8'h5d, 1'b1);
		get(8'ha5);
		m.stop();
		m.start();
		put(8'h5d, 1'b1);
		get(8'ha5);
		m.start();
		put(8'h5e, 1'b0);
		m.start();
		put(8'h5c, 1'b1);
		put(8'h20, 1'b1);
		put(8'h11, 1'b1);
		put(8'h22, 1'b0);
		m.stop();
		repeat (20) @(negedge clk_i);
		chk("reg20", 8'h11, regs[8'h20]);
		m.start();
		put(8'h5c, 1'b1);
		put(8'h40, 1'b1);
		m.start();
		put(8'h5d, 1'b1);
		repeat (10) @(negedge clk_i);
		chk("sda_oe", 8'h01, {7'h0, sda_oe});
		repeat (300) @(negedge clk_i);
		chk("sda_oe", 8'h00, {7'h0, sda_oe});
		m.stop();
		wreg(8'h40, 8'h40);
		chk("cfg1", 8'h40, cfg1);
		m.start();
		put(8'h5d, 1'b1);
		repeat (310) @(negedge clk_i);
		chk("sda_oe", 8'h01, {7'h0, sda_oe});
		get(8'h40);
		m.stop();
		wreg(8'h40, 8'h42);
		chk("lock", 8'h01, {7'h0, lock});
		wreg(8'h50, 8'h33);
		wreg(8'h40, 8'h00);
		wreg(8'h10, 8'h77);
		chk("wr_count", 8'h03, 8'(wr_count));
		chk("cfg1", 8'h42, cfg1);
		alert_cond_i = 1'b1;
		repeat (3) @(negedge clk_i);
		chk("alert_n", 8'h00, {7'h0, alert_n});
		m.start();
		put(8'h19, 1'b1);
		get(8'h5c);
		m.stop();
		repeat (5) @(negedge clk_i);
		chk("alert_n", 8'h00, {7'h0, alert_n});
		alert_cond_i = 1'b0;
		// a lower address wins the reply, the alert must stay
		m.start();
		put(8'h19, 1'b1);
		m.byte_io(8'h58, 1'b0, r, a);
		chk("ara_lost", 8'h58, r);
		m.stop();
		repeat (5) @(negedge clk_i);
		chk("alert_n", 8'h00, {7'h0, alert_n});
		m.start();
		put(8'h19, 1'b1);
		get(8'h5c);
		m.stop();
		repeat (5) @(negedge clk_i);
		chk("alert_n", 8'h01, {7'h0, alert_n});
		m.start();
		put(8'h19, 1'b0);
		m.stop();
		// only a reset clears the lock
		rst_n_i = 1'b0;
		repeat (3) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (5) @(negedge clk_i);
		chk("lock", 8'h00, {7'h0, lock});
		chk("cfg1", 8'h00, cfg1);
		wreg(8'h50, 8'h5a);
		chk("reg50", 8'h5a, regs[8'h50]);
		give_verdict();
	end
endmodule
